/* logic/hps_pkg.sv */
// constants for the root port status/control and descriptor map register bank
// Summary of operation
// - zero test field normal, nonzero selects test
// - indicator writes ignored without indicator capability
// - owner clears when configured bit rises
// - owner held one while configured bit zero
// - feed bit behaviour follows feed switch capability
// - line field shows D+ bit11, D- bit10
// - reset bit one while port in reset
// - sleep bit one while port suspended
// - wake bit one while resume detected/driven
// - enable bit one means port enabled
// - change bit set when attach state changes
// - attach bit one while peripheral present
// - reset, sleep, wake, enable, change and attach bits read zero while unpowered
// - completion bit set when descriptor finishes
// - reading completion map clears its set bits
// - bypass bit skips descriptor; map resets ones
// - skipped descriptor content never processed
// - scan stops after final mark, then restarts
// - final mark is bitmap, resets zero
package hps_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_DESC = 32;
  // register byte offsets
  localparam logic [11:0] OFS_CONFIG_DONE = 12'h060;
  localparam logic [11:0] OFS_PORT_CS     = 12'h064;
  localparam logic [11:0] OFS_ISO_DONE    = 12'h130;
  localparam logic [11:0] OFS_ISO_BYPASS  = 12'h134;
  localparam logic [11:0] OFS_ISO_FINAL   = 12'h138;
  localparam logic [11:0] OFS_INT_DONE    = 12'h140;
  // port control/status field positions
  localparam int POS_TEST_HI  = 19;
  localparam int POS_TEST_LO  = 16;
  localparam int POS_IND_HI   = 15;
  localparam int POS_IND_LO   = 14;
  localparam int POS_OWNER    = 13;
  localparam int POS_FEED     = 12;
  localparam int POS_LINE_DP  = 11;
  localparam int POS_LINE_DM  = 10;
  localparam int POS_RESET    = 8;
  localparam int POS_SLEEP    = 7;
  localparam int POS_WAKE     = 6;
  localparam int POS_ENABLE   = 2;
  localparam int POS_CHANGE   = 1;
  localparam int POS_ATTACH   = 0;
  localparam int POS_CONFIGURED = 0;
  // reset values
  localparam logic [31:0] RST_ISO_DONE   = 32'h0000_0000;
  localparam logic [31:0] RST_ISO_BYPASS = 32'hffff_ffff;
  localparam logic [31:0] RST_ISO_FINAL  = 32'h0000_0000;
  localparam logic [31:0] RST_INT_DONE   = 32'h0000_0000;
  localparam logic [3:0]  RST_TEST       = 4'h0;
  localparam logic [1:0]  RST_IND        = 2'h0;
  localparam logic        RST_OWNER      = 1'b1;
  // full speed K state on {dp, dm}
  localparam logic [1:0]  LINE_K         = 2'h1;
  localparam logic [4:0]  LAST_INDEX     = 5'h1f;
endpackage

/* logic/hps_port_maps.sv */
// root port status/control and descriptor scheduling map register bank
`timescale 1ns/1ps
`default_nettype none
module hps_port_maps
  import hps_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // structural capabilities
  input  wire logic              cap_indicator,
  input  wire logic              cap_feed_switch,
  // port line pins
  input  wire logic              line_dp,
  input  wire logic              line_dm,
  input  wire logic              peer_present,
  // port controls
  output logic [3:0]             test_mode,
  output logic                   test_active,
  output logic [1:0]             indicator,
  output logic                   owner,
  output logic                   feed_on,
  output logic                   reset_drive,
  output logic                   sleep_on,
  output logic                   wake_drive,
  output logic                   link_enabled,
  // descriptor engine side
  input  wire logic [31:0]       iso_valid,
  input  wire logic              exec_ready,
  output logic                   iso_issue,
  output logic [4:0]             iso_issue_idx,
  input  wire logic              iso_done_evt,
  input  wire logic [4:0]        iso_done_idx,
  input  wire logic              int_done_evt,
  input  wire logic [4:0]        int_done_idx
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic        attach_prev_q;
  logic        cf_q;
  logic        cf_prev_q;
  logic [3:0]  test_q;
  logic [1:0]  ind_q;
  logic        owner_q;
  logic        feed_q;
  logic        reset_q;
  logic        sleep_q;
  logic        wake_q;
  logic        enable_q;
  logic        change_q;
  logic [31:0] iso_done_q;
  logic [31:0] iso_bypass_q;
  logic [31:0] iso_final_q;
  logic [31:0] int_done_q;
  logic [4:0]  scan_idx_q;
  logic        issue_q;
  logic [4:0]  issue_idx_q;

  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        wr_port;
  logic [31:0] wd_port;
  logic [31:0] port_view;
  logic [31:0] rmux;
  logic        line_dp_s;
  logic        line_dm_s;
  logic        attach_s;
  logic        feed_now;
  logic        k_seen;
  // merge write data into old value by byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      r[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then accept
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_acc = avs_write & ack_q;
  assign rd_acc = avs_read & ack_q;
  assign wr_port = wr_acc && (avs_address == OFS_PORT_CS);
  assign wd_port = lane_merge(port_view, avs_writedata, avs_byteenable);
  assign avs_readdata = rdata_q;

  // acknowledge toggles while a request is held
  always_ff @(posedge clock)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // read data captured the cycle before acceptance
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read & ~ack_q)
      rdata_q <= rmux;
  end

  // read decode, unmapped reads zero
  always_comb
  begin
    if (avs_address == OFS_CONFIG_DONE)
      rmux = {31'h0000_0000, cf_q};
    else if (avs_address == OFS_PORT_CS)
      rmux = port_view;
    else if (avs_address == OFS_ISO_DONE)
      rmux = iso_done_q;
    else if (avs_address == OFS_ISO_BYPASS)
      rmux = iso_bypass_q;
    else if (avs_address == OFS_ISO_FINAL)
      rmux = iso_final_q;
    else if (avs_address == OFS_INT_DONE)
      rmux = int_done_q;
    else
      rmux = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {peer_present, line_dp, line_dm};
      sync2_q <= sync1_q;
    end
  end
  assign line_dm_s = sync2_q[0];
  assign line_dp_s = sync2_q[1];
  assign attach_s  = sync2_q[2];
  assign k_seen = ({line_dp_s, line_dm_s} == LINE_K);
  ////////////////////////////////////////////////////////////////////////
  // port control/status view
  always_comb
  begin
    port_view = 32'h0000_0000;
    port_view[POS_TEST_HI:POS_TEST_LO] = test_q;
    port_view[POS_IND_HI:POS_IND_LO] = ind_q;
    port_view[POS_OWNER] = owner_q;
    port_view[POS_FEED] = feed_now;
    port_view[POS_LINE_DP] = line_dp_s;
    port_view[POS_LINE_DM] = line_dm_s;
    if (feed_now)
    begin
      port_view[POS_RESET]  = reset_q;
      port_view[POS_SLEEP]  = sleep_q;
      port_view[POS_WAKE]   = wake_q;
      port_view[POS_ENABLE] = enable_q;
      port_view[POS_CHANGE] = change_q;
      port_view[POS_ATTACH] = attach_s;
    end
  end

  // feed is fixed on without switch capability
  assign feed_now = cap_feed_switch ? feed_q : 1'b1;
  // configured flag and its previous value
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cf_q <= 1'b0;
      cf_prev_q <= 1'b0;
    end
    else
    begin
      cf_prev_q <= cf_q;
      if (wr_acc && (avs_address == OFS_CONFIG_DONE) && avs_byteenable[0])
        cf_q <= avs_writedata[POS_CONFIGURED];
    end
  end

  // owner handoff
  always_ff @(posedge clock)
  begin
    if (rst)
      owner_q <= RST_OWNER;
    else if (!cf_q)
      owner_q <= 1'b1;
    else if (!cf_prev_q)
      owner_q <= 1'b0;
    else if (wr_port)
      owner_q <= wd_port[POS_OWNER];
  end

  // test select, indicator and feed
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      test_q <= RST_TEST;
      ind_q <= RST_IND;
      feed_q <= 1'b0;
    end
    else if (wr_port)
    begin
      test_q <= wd_port[POS_TEST_HI:POS_TEST_LO];
      if (cap_indicator)
        ind_q <= wd_port[POS_IND_HI:POS_IND_LO];
      if (cap_feed_switch)
        feed_q <= wd_port[POS_FEED];
    end
  end

  // reset, enable, sleep and wake state
  always_ff @(posedge clock)
  begin
    if (rst || !feed_now)
    begin
      reset_q <= 1'b0;
      enable_q <= 1'b0;
      sleep_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      if (!attach_s)
        enable_q <= 1'b0;
      else if (wr_port && reset_q && !wd_port[POS_RESET])
        enable_q <= 1'b1;
      else if (wr_port && (wd_port[POS_RESET] || !wd_port[POS_ENABLE]))
        enable_q <= 1'b0;
      if (wr_port)
        reset_q <= wd_port[POS_RESET];
      if (wr_port && wake_q && !wd_port[POS_WAKE])
        sleep_q <= 1'b0;
      else if (wr_port && wd_port[POS_RESET])
        sleep_q <= 1'b0;
      else if (wr_port && enable_q && wd_port[POS_SLEEP])
        sleep_q <= 1'b1;
      if (sleep_q && k_seen)
        wake_q <= 1'b1;
      else if (wr_port)
        wake_q <= wd_port[POS_WAKE];
    end
  end

  // connect change, set wins over write-one clear
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      attach_prev_q <= 1'b0;
      change_q <= 1'b0;
    end
    else
    begin
      attach_prev_q <= attach_s;
      if (attach_s != attach_prev_q)
        change_q <= 1'b1;
      else if (wr_port && avs_writedata[POS_CHANGE] && avs_byteenable[0])
        change_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // completion maps: event set wins, read clears only bits returned
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      iso_done_q <= RST_ISO_DONE;
      int_done_q <= RST_INT_DONE;
    end
    else
    begin
      iso_done_q <= (iso_done_q & ~((rd_acc && (avs_address == OFS_ISO_DONE)) ? rdata_q : 32'h0000_0000))
                    | (iso_done_evt ? (32'h0000_0001 << iso_done_idx) : 32'h0000_0000);
      int_done_q <= (int_done_q & ~((rd_acc && (avs_address == OFS_INT_DONE)) ? rdata_q : 32'h0000_0000))
                    | (int_done_evt ? (32'h0000_0001 << int_done_idx) : 32'h0000_0000);
    end
  end

  // bypass and final mark maps
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      iso_bypass_q <= RST_ISO_BYPASS;
      iso_final_q <= RST_ISO_FINAL;
    end
    else if (wr_acc && (avs_address == OFS_ISO_BYPASS))
      iso_bypass_q <= lane_merge(iso_bypass_q, avs_writedata, avs_byteenable);
    else if (wr_acc && (avs_address == OFS_ISO_FINAL))
      iso_final_q <= lane_merge(iso_final_q, avs_writedata, avs_byteenable);
  end
  ////////////////////////////////////////////////////////////////////////
  // isochronous scan: one index per ready cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      scan_idx_q <= 5'h00;
      issue_q <= 1'b0;
      issue_idx_q <= 5'h00;
    end
    else if (exec_ready)
    begin
      issue_q <= iso_valid[scan_idx_q] & ~iso_bypass_q[scan_idx_q];
      issue_idx_q <= scan_idx_q;
      if (iso_final_q[scan_idx_q] || (scan_idx_q == LAST_INDEX))
        scan_idx_q <= 5'h00;
      else
        scan_idx_q <= scan_idx_q + 5'h01;
    end
    else
      issue_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign test_mode = test_q;
  assign test_active = (test_q != 4'h0);
  assign indicator = ind_q;
  assign owner = owner_q;
  assign feed_on = feed_now;
  assign reset_drive = reset_q;
  assign sleep_on = sleep_q;
  assign wake_drive = wake_q;
  assign link_enabled = enable_q;
  assign iso_issue = issue_q;
  assign iso_issue_idx = issue_idx_q;
  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_done_read;
    rd_acc && (avs_address == OFS_ISO_DONE) && !iso_done_evt;
  endsequence
  sequence s_cf_rise;
    cf_q && !cf_prev_q;
  endsequence
  property p_test_active;
    @(posedge clock) disable iff (rst) test_active == (test_mode != 4'h0);
  endproperty
  a_test_active: assert property (p_test_active) else $error("test active wrong");
  property p_ind_locked;
    @(posedge clock) disable iff (rst) (wr_port && !cap_indicator) |=> $stable(indicator);
  endproperty
  a_ind_locked: assert property (p_ind_locked) else $error("indicator changed");
  property p_owner_rise;
    @(posedge clock) disable iff (rst) s_cf_rise ##1 cf_q |-> !owner_q;
  endproperty
  a_owner_rise: assert property (p_owner_rise) else $error("owner not cleared");
  property p_owner_hold;
    @(posedge clock) disable iff (rst) !cf_q |=> owner_q;
  endproperty
  a_owner_hold: assert property (p_owner_hold) else $error("owner not held");
  property p_line_view;
    @(posedge clock) disable iff (rst) ##2 (port_view[POS_LINE_DP] == $past(line_dp, 2));
  endproperty
  a_line_view: assert property (p_line_view) else $error("line level wrong");
  property p_unpowered;
    @(posedge clock) disable iff (rst) !feed_now |-> (port_view[8:0] == 9'h000);
  endproperty
  a_unpowered: assert property (p_unpowered) else $error("fields not zero");
  property p_change;
    @(posedge clock) disable iff (rst) (attach_s != attach_prev_q) |=> change_q;
  endproperty
  a_change: assert property (p_change) else $error("change missed");
  property p_done_set;
    @(posedge clock) disable iff (rst) iso_done_evt |=> iso_done_q[$past(iso_done_idx)];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done bit not set");
  property p_done_clear;
    @(posedge clock) disable iff (rst) s_done_read |=> ((iso_done_q & $past(rdata_q)) == 32'h0000_0000);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("read did not clear");
  property p_bypass;
    @(posedge clock) disable iff (rst) (exec_ready && iso_bypass_q[scan_idx_q]) |=> !iso_issue;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed issued");
  property p_final_wrap;
    @(posedge clock) disable iff (rst) (exec_ready && iso_final_q[scan_idx_q]) |=> (scan_idx_q == 5'h00);
  endproperty
  a_final_wrap: assert property (p_final_wrap) else $error("no restart");
endmodule
`default_nettype wire

/* verif/hps_peer_dev.sv */
// model of the full speed peripheral attached to the root port
`timescale 1ns/1ps
`default_nettype none
module hps_peer_dev
(
  // commands from the bench
  input  wire logic attach,
  input  wire logic resume_k,
  // port lines
  output logic      line_dp,
  output logic      line_dm,
  output logic      peer_present
);
  // idle J when attached, K while resuming; detached lines fall to the host pull-downs
  assign peer_present = attach;
  assign line_dp      = attach & ~resume_k;
  assign line_dm      = attach & resume_k;
endmodule
`default_nettype wire

/* verif/hps_port_maps_tb_top.sv */
// self-checking bench for the root port and descriptor map register bank
`timescale 1ns/1ps
`default_nettype none
module hps_port_maps_tb_top;
  import hps_pkg::*;
  logic        clock = 1'b0, rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, iso_valid = 32'h0000_0000;
  logic        avs_waitrequest, cap_indicator = 1'b0, cap_feed_switch = 1'b1;
  logic        line_dp, line_dm, peer_present, attach = 1'b0, resume_k = 1'b0;
  logic [3:0]  test_mode;
  logic [1:0]  indicator;
  logic        test_active, owner, feed_on, reset_drive, sleep_on, wake_drive, link_enabled;
  logic        exec_ready = 1'b0, iso_issue, iso_done_evt = 1'b0, int_done_evt = 1'b0;
  logic [4:0]  iso_issue_idx, iso_done_idx = 5'h00, int_done_idx = 5'h00;
  logic [4:0]  issued[$];
  int          err_total = 0, num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #2 clock = ~clock;
  hps_port_maps u_hps_port_maps (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_indicator(cap_indicator), .cap_feed_switch(cap_feed_switch),
    .line_dp(line_dp), .line_dm(line_dm), .peer_present(peer_present), .test_mode(test_mode),
    .test_active(test_active), .indicator(indicator), .owner(owner), .feed_on(feed_on),
    .reset_drive(reset_drive), .sleep_on(sleep_on), .wake_drive(wake_drive), .link_enabled(link_enabled),
    .iso_valid(iso_valid), .exec_ready(exec_ready), .iso_issue(iso_issue), .iso_issue_idx(iso_issue_idx),
    .iso_done_evt(iso_done_evt), .iso_done_idx(iso_done_idx), .int_done_evt(int_done_evt),
    .int_done_idx(int_done_idx));
  hps_peer_dev u_hps_peer_dev (.attach(attach), .resume_k(resume_k), .line_dp(line_dp), .line_dm(line_dm),
    .peer_present(peer_present));
  // record issued descriptors mid-cycle, where the pulse has settled
  always @(negedge clock)
    if (iso_issue === 1'b1)
      issued.push_back(iso_issue_idx);
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] pv(input logic [3:0] t, input logic [1:0] i, input logic o, f,
                                     input logic [1:0] ln, input logic r, s, w, e, c, a);
    return {12'h000, t, i, o, f, ln, 1'b0, r, s, w, 3'h0, e, c, a};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer; held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q & m, exp);
  endtask
  task automatic evt(input logic iso, input logic [4:0] idx);
    @(posedge clock);
    iso_done_evt <= iso;
    int_done_evt <= ~iso;
    iso_done_idx <= idx;
    int_done_idx <= idx;
    @(posedge clock);
    iso_done_evt <= 1'b0;
    int_done_evt <= 1'b0;
  endtask
  // scan six indices from zero and compare the issued order, first index in the low bits
  task automatic scan(input logic [31:0] byp, input int n, input logic [19:0] seq);
    wr(OFS_ISO_BYPASS, byp);
    issued.delete();
    @(posedge clock);
    exec_ready <= 1'b1;
    repeat (6) @(posedge clock);
    exec_ready <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(issued.size()), 32'(n));
    for (int k = 0; k < n && k < issued.size(); k++)
      chk({27'h0, issued[k]}, {27'h0, seq[5*k +: 5]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    iso_valid <= 32'h0000_0005;
    rc(OFS_PORT_CS, 32'h0000_2000);
    rc(OFS_ISO_BYPASS, RST_ISO_BYPASS);
    rc(OFS_ISO_FINAL, RST_ISO_FINAL);
    rc(OFS_ISO_DONE, RST_ISO_DONE);
    rc(OFS_INT_DONE, RST_INT_DONE);
    wr(12'h200, 32'h1234_5678);
    rc(12'h200, 32'h0000_0000);
    $display("test reset_and_unmapped done");
    wr(OFS_CONFIG_DONE, 32'h0000_0001);
    rc(OFS_PORT_CS, 32'h0000_0000, 32'h0000_2000);
    chk({31'h0, owner}, 32'h0000_0000);
    wr(OFS_CONFIG_DONE, 32'h0000_0000);
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    rc(OFS_PORT_CS, 32'h0000_2000, 32'h0000_2000);
    wr(OFS_CONFIG_DONE, 32'h0000_0001);
    $display("test owner done");
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    attach <= 1'b1;
    repeat (6) @(posedge clock);
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    chk({31'h0, reset_drive}, 32'h0000_0001);
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    chk({31'h0, link_enabled}, 32'h0000_0001);
    $display("test attach_reset done");
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
    resume_k <= 1'b1;
    repeat (6) @(posedge clock);
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
    chk({30'h0, sleep_on, wake_drive}, 32'h0000_0003);
    resume_k <= 1'b0;
    repeat (6) @(posedge clock);
    wr(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, pv(4'h0, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    chk({30'h0, sleep_on, wake_drive}, 32'h0000_0000);
    $display("test sleep_wake done");
    wr(OFS_PORT_CS, pv(4'h5, 2'h3, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, 32'h0005_0000, 32'h000f_c000);
    chk({27'h0, test_active, test_mode}, 32'h0000_0015);
    chk({30'h0, indicator}, 32'h0000_0000);
    cap_indicator <= 1'b1;
    wr(OFS_PORT_CS, pv(4'h0, 2'h2, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, 32'h0000_8000, 32'h000f_c000);
    chk({27'h0, test_active, test_mode}, 32'h0000_0000);
    chk({30'h0, indicator}, 32'h0000_0002);
    $display("test test_indicator done");
    evt(1'b1, 5'h03);
    evt(1'b1, 5'h1f);
    evt(1'b0, 5'h00);
    rc(OFS_ISO_DONE, 32'h8000_0008);
    rc(OFS_ISO_DONE, 32'h0000_0000);
    rc(OFS_INT_DONE, 32'h0000_0001);
    rc(OFS_INT_DONE, 32'h0000_0000);
    $display("test done_maps done");
    wr(OFS_ISO_FINAL, 32'h0000_0004);
    scan(32'h0000_0000, 4, {5'h02, 5'h00, 5'h02, 5'h00});
    scan(32'h0000_0001, 2, {10'h000, 5'h02, 5'h02});
    $display("test scan done");
    wr(OFS_PORT_CS, pv(4'h0, 2'h2, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    rc(OFS_PORT_CS, pv(4'h0, 2'h2, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    cap_feed_switch <= 1'b0;
    rc(OFS_PORT_CS, 32'h0000_1000, 32'h0000_1000);
    chk({31'h0, feed_on}, 32'h0000_0001);
    $display("test power done");
    finish_test();
  end
endmodule
`default_nettype wire
